// ### rtl/tbx_cfg.svh
`ifndef TBX_CFG_SVH
`define TBX_CFG_SVH

// Link command words: command byte then data byte
`define TBX_CMD_GEN 8'h80
`define TBX_CMD_PMC 8'h82
`define TBX_CMD_TXB 8'hB8
`define TBX_GEN_TXREN_BIT 7
`define TBX_GEN_POL_BIT 4
`define TBX_GEN_DEVW_MSB 3
`define TBX_GEN_DEVW_LSB 0
`define TBX_PMC_TXEN_BIT 5
`define TBX_PREAMBLE 8'hAA
`define TBX_WORD_BITS 5'h10
`define TBX_BYTE_BITS 5'h08
`define TBX_DEV_STEP_KHZ 8'h0F

// Timing
`define TBX_HCLK_MHZ 50
`define TBX_BIT_CYCLES 100
`define TBX_CAL_CYCLES 64
`define TBX_SCK_HALF 4
`define TBX_GUARD_BITS 16

// Host register map and reset values
`define TBX_OFS_CTRL 8'h00
`define TBX_OFS_CMD 8'h04
`define TBX_OFS_FRAME 8'h08
`define TBX_OFS_STATUS 8'h0C
`define TBX_OFS_INT_STAT 8'h10
`define TBX_OFS_INT_MASK 8'h14
`define TBX_CTRL_RST 1'b1
`define TBX_INT_BITS 3
`define TBX_INT_RISE 0
`define TBX_INT_FALL 1
`define TBX_INT_DONE 2
`define TBX_INT_MASK_RST 3'h0
`endif

// ### rtl/tbx_device.sv
`timescale 1ns/1ps
`include "tbx_cfg.svh"
module tbx_device #(
    parameter int BIT_CYCLES = `TBX_BIT_CYCLES,
    parameter int CAL_CYCLES = `TBX_CAL_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    tbx_link_if.dev link,
    output logic osc_on,
    output logic synth_on,
    output logic pa_on,
    output logic tx_active,
    output logic fsk_bit,
    output logic rf_sign,
    output logic [7:0] dev_khz
);
    if (BIT_CYCLES < 1 || BIT_CYCLES > 65536) begin
        $error("tbx_device: BIT_CYCLES out of range");
    end
    if (CAL_CYCLES < 1 || CAL_CYCLES > 65536) begin
        $error("tbx_device: CAL_CYCLES out of range");
    end

    logic sck_s;
    logic sdi_s;
    logic cs_n_s;
    logic pin_s;
    logic sck_d;
    logic frame_d;
    logic frame_select_input_frame;
    logic [15:0] rx_word;
    logic [4:0] rx_cnt;
    logic tx_register_enable;
    logic txren_d;
    logic deviation_polarity_bit;
    logic [3:0] deviation_width_field;
    logic transmitter_enable;
    tbx_pkg::tbx_tx_state_e state;
    tbx_pkg::tbx_tx_state_e next_state;
    logic [15:0] cal_tmr;
    logic [15:0] bit_tmr;
    logic [7:0] shift_reg;
    logic [7:0] hold_reg;
    logic [2:0] bit_idx;
    logic refill_req;
    logic irq_q;
    logic sdo_q;

    // Pins come from the host's clock domain
    tbx_sync #(.WIDTH(4), .INIT(4'h3)) u_sync (
        .clk(hclk),
        .rst_n(hresetn),
        .d({link.sck, link.sdi, link.cs_n, link.data_pin}),
        .q({sck_s, sdi_s, cs_n_s, pin_s})
    );

    wire sck_rise = sck_s & ~sck_d;
    wire frame_select_input_low = tx_register_enable & ~pin_s;
    wire frame = ~cs_n_s | frame_select_input_low;
    wire frame_end = frame_d & ~frame;
    wire word_ok = frame_end & ~frame_select_input_frame & (rx_cnt == `TBX_WORD_BITS);
    wire wr_gen = word_ok & (rx_word[15:8] == `TBX_CMD_GEN);
    wire wr_pmc = word_ok & (rx_word[15:8] == `TBX_CMD_PMC);
    wire wr_txb = word_ok & (rx_word[15:8] == `TBX_CMD_TXB);
    wire wr_frame_select_input = frame_end & frame_select_input_frame & (rx_cnt == `TBX_BYTE_BITS);
    wire wr_byte = wr_txb | wr_frame_select_input;
    wire txreg_rise = tx_register_enable & ~txren_d;
    wire sending = (state == tbx_pkg::TBX_SEND) & tx_register_enable;
    wire bit_tick = sending & (bit_tmr == 16'(BIT_CYCLES - 1));
    wire byte_done = bit_tick & (bit_idx == 3'h7);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sck_d <= 1'b0;
            frame_d <= 1'b0;
            txren_d <= 1'b0;
        end else begin
            sck_d <= sck_s;
            frame_d <= frame;
            txren_d <= tx_register_enable;
        end
    end

    // Serial receive, MSB first on rising clock edges
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_word <= 16'h0000;
            rx_cnt <= 5'h00;
            frame_select_input_frame <= 1'b0;
        end else if (!frame) begin
            rx_cnt <= 5'h00;
            if (!frame_d) begin
                frame_select_input_frame <= 1'b0;
            end
        end else begin
            if (!frame_d) begin
                frame_select_input_frame <= frame_select_input_low & cs_n_s;
            end
            if (sck_rise) begin
                rx_word <= {rx_word[14:0], sdi_s};
                if (rx_cnt != 5'h1F) begin
                    rx_cnt <= rx_cnt + 5'h01;
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_register_enable <= 1'b0;
            deviation_polarity_bit <= 1'b0;
            deviation_width_field <= 4'h0;
        end else if (wr_gen) begin
            tx_register_enable <= rx_word[`TBX_GEN_TXREN_BIT];
            deviation_polarity_bit <= rx_word[`TBX_GEN_POL_BIT];
            deviation_width_field <= rx_word[`TBX_GEN_DEVW_MSB:`TBX_GEN_DEVW_LSB];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            transmitter_enable <= 1'b0;
        end else if (wr_pmc) begin
            transmitter_enable <= rx_word[`TBX_PMC_TXEN_BIT];
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            tbx_pkg::TBX_OFF: begin
                if (transmitter_enable) begin
                    next_state = tbx_pkg::TBX_CAL;
                end
            end
            tbx_pkg::TBX_CAL: begin
                if (!transmitter_enable) begin
                    next_state = tbx_pkg::TBX_OFF;
                end else if (cal_tmr == 16'(CAL_CYCLES - 1)) begin
                    next_state = tbx_pkg::TBX_SEND;
                end
            end
            tbx_pkg::TBX_SEND: begin
                if (!transmitter_enable) begin
                    next_state = tbx_pkg::TBX_OFF;
                end
            end
            default: begin
                next_state = tbx_pkg::TBX_OFF;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= tbx_pkg::TBX_OFF;
        end else begin
            state <= next_state;
        end
    end

    // Calibration time of the synthesizer before the amplifier comes up
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cal_tmr <= 16'h0000;
        end else if (state != tbx_pkg::TBX_CAL) begin
            cal_tmr <= 16'h0000;
        end else begin
            cal_tmr <= cal_tmr + 16'h0001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_on <= 1'b0;
            synth_on <= 1'b0;
            pa_on <= 1'b0;
            tx_active <= 1'b0;
        end else begin
            osc_on <= transmitter_enable;
            synth_on <= transmitter_enable;
            pa_on <= (next_state == tbx_pkg::TBX_SEND);
            tx_active <= (next_state == tbx_pkg::TBX_SEND) & tx_register_enable;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bit_tmr <= 16'h0000;
        end else if (!sending || bit_tick) begin
            bit_tmr <= 16'h0000;
        end else begin
            bit_tmr <= bit_tmr + 16'h0001;
        end
    end

    // The shifter reloads from the holding register on the last bit tick,
    // so there is no idle bit between bytes; an empty refill resends it.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shift_reg <= `TBX_PREAMBLE;
            bit_idx <= 3'h0;
        end else if (txreg_rise) begin
            shift_reg <= `TBX_PREAMBLE;
            bit_idx <= 3'h0;
        end else if (byte_done) begin
            shift_reg <= hold_reg;
            bit_idx <= 3'h0;
        end else if (bit_tick) begin
            shift_reg <= {shift_reg[6:0], 1'b0};
            bit_idx <= bit_idx + 3'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_reg <= `TBX_PREAMBLE;
        end else if (txreg_rise) begin
            hold_reg <= `TBX_PREAMBLE;
        end else if (wr_byte && tx_register_enable) begin
            hold_reg <= rx_word[7:0];
        end
    end

    // Underrun request: a byte completion wins over a same-cycle refill
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            refill_req <= 1'b0;
        end else if (!tx_register_enable) begin
            refill_req <= 1'b0;
        end else if (byte_done) begin
            refill_req <= 1'b1;
        end else if (wr_byte) begin
            refill_req <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_q <= 1'b1;
            sdo_q <= 1'b0;
        end else if (!tx_register_enable) begin
            irq_q <= 1'b1;
            sdo_q <= 1'b0;
        end else begin
            irq_q <= refill_req;
            sdo_q <= ~refill_req;
        end
    end

    assign link.irq = irq_q;
    assign link.sdo = sdo_q;

    // Buffered mode modulates from the shifter, otherwise the raw pin
    wire mod_bit = tx_register_enable ? shift_reg[7] : pin_s;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fsk_bit <= 1'b0;
            rf_sign <= 1'b0;
            dev_khz <= `TBX_DEV_STEP_KHZ;
        end else begin
            fsk_bit <= mod_bit;
            rf_sign <= deviation_polarity_bit ^ mod_bit;
            dev_khz <= ({4'h0, deviation_width_field} + 8'h01) * `TBX_DEV_STEP_KHZ;
        end
    end
endmodule

// ### rtl/tbx_host.sv
`timescale 1ns/1ps
`include "tbx_cfg.svh"
module tbx_host #(
    parameter int SCK_HALF = `TBX_SCK_HALF,
    parameter int GUARD_CYCLES = `TBX_GUARD_BITS * `TBX_BIT_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    output logic host_irq,
    tbx_link_if.host link
);
    if (SCK_HALF < 2 || SCK_HALF > 255) begin
        $error("tbx_host: SCK_HALF out of range");
    end
    if (GUARD_CYCLES < 1 || GUARD_CYCLES > 16777215) begin
        $error("tbx_host: GUARD_CYCLES out of range");
    end

    logic irq_s;
    logic sdo_s;
    logic irq_d;
    logic dp_wr;
    logic [7:0] dp_addr;
    logic pin_level;
    logic [2:0] int_stat;
    logic [2:0] int_mask;
    tbx_pkg::tbx_spi_state_e spi_state;
    logic [15:0] sh;
    logic [4:0] cnt;
    logic [7:0] div;
    logic frame_select_input_mode;
    logic sck_q;
    logic sdi_q;
    logic cs_n_q;
    logic spi_done;
    logic [23:0] guard_cnt;
    logic guard_ok;
    logic data_pin_q;

    // Reset levels match the device's idle pins, so no false edge follows reset
    tbx_sync #(.WIDTH(2), .INIT(2'h2)) u_sync (
        .clk(hclk),
        .rst_n(hresetn),
        .d({link.irq, link.sdo}),
        .q({irq_s, sdo_s})
    );

    wire ap_take = hsel & hready & htrans[1];
    wire busy = (spi_state == tbx_pkg::TBX_SPI_SHIFT);
    wire wr_cmd = dp_wr & (dp_addr == `TBX_OFS_CMD) & ~busy;
    wire wr_frame = dp_wr & (dp_addr == `TBX_OFS_FRAME) & ~busy;
    wire half_end = (div == 8'(SCK_HALF - 1));
    wire [2:0] int_set = {spi_done, irq_d & ~irq_s, irq_s & ~irq_d};
    wire [2:0] int_clr = (dp_wr && dp_addr == `TBX_OFS_INT_STAT) ? hwdata[2:0] : 3'h0;
    wire txb_word = wr_cmd & (hwdata[15:8] == `TBX_CMD_TXB);

    // Zero-wait slave: read data is registered at the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr <= 1'b0;
            dp_addr <= 8'h00;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            dp_wr <= ap_take & hwrite;
            dp_addr <= haddr[7:0];
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (ap_take && !hwrite) begin
                case (haddr[7:0])
                    `TBX_OFS_CTRL: hrdata <= {31'h0, pin_level};
                    `TBX_OFS_STATUS: hrdata <= {28'h0, guard_ok, sdo_s, irq_s, busy};
                    `TBX_OFS_INT_STAT: hrdata <= {29'h0, int_stat};
                    `TBX_OFS_INT_MASK: hrdata <= {29'h0, int_mask};
                    default: hrdata <= 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_level <= `TBX_CTRL_RST;
            int_mask <= `TBX_INT_MASK_RST;
        end else if (dp_wr && dp_addr == `TBX_OFS_CTRL) begin
            pin_level <= hwdata[0];
        end else if (dp_wr && dp_addr == `TBX_OFS_INT_MASK) begin
            int_mask <= hwdata[2:0];
        end
    end

    // Sticky events: a set in the clearing cycle survives
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_d <= 1'b1;
            int_stat <= 3'h0;
            host_irq <= 1'b0;
        end else begin
            irq_d <= irq_s;
            int_stat <= int_set | (int_stat & ~int_clr);
            host_irq <= |((int_set | (int_stat & ~int_clr)) & int_mask);
        end
    end

    // Link master: data changes on falling clock, device samples rising
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            spi_state <= tbx_pkg::TBX_SPI_IDLE;
            sh <= 16'h0000;
            cnt <= 5'h00;
            div <= 8'h00;
            frame_select_input_mode <= 1'b0;
            sck_q <= 1'b0;
            sdi_q <= 1'b0;
            cs_n_q <= 1'b1;
            spi_done <= 1'b0;
        end else begin
            spi_done <= 1'b0;
            case (spi_state)
                tbx_pkg::TBX_SPI_IDLE: begin
                    div <= 8'h00;
                    if (wr_cmd) begin
                        sh <= hwdata[15:0];
                        sdi_q <= hwdata[15];
                        cnt <= `TBX_WORD_BITS;
                        cs_n_q <= 1'b0;
                        spi_state <= tbx_pkg::TBX_SPI_SHIFT;
                    end else if (wr_frame) begin
                        sh <= {hwdata[7:0], 8'h00};
                        sdi_q <= hwdata[7];
                        cnt <= `TBX_BYTE_BITS;
                        frame_select_input_mode <= 1'b1;
                        spi_state <= tbx_pkg::TBX_SPI_SHIFT;
                    end
                end
                tbx_pkg::TBX_SPI_SHIFT: begin
                    div <= half_end ? 8'h00 : div + 8'h01;
                    if (half_end && !sck_q) begin
                        sck_q <= 1'b1;
                    end else if (half_end) begin
                        sck_q <= 1'b0;
                        cnt <= cnt - 5'h01;
                        sh <= {sh[14:0], 1'b0};
                        sdi_q <= sh[14];
                        if (cnt == 5'h01) begin
                            cs_n_q <= 1'b1;
                            frame_select_input_mode <= 1'b0;
                            spi_done <= 1'b1;
                            spi_state <= tbx_pkg::TBX_SPI_IDLE;
                        end
                    end
                end
                default: begin
                    spi_state <= tbx_pkg::TBX_SPI_IDLE;
                end
            endcase
        end
    end

    // Guard time after the last byte load for turning off without a dummy
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            guard_cnt <= 24'h000000;
            guard_ok <= 1'b1;
        end else if (wr_frame || txb_word) begin
            guard_cnt <= 24'h000000;
            guard_ok <= 1'b0;
        end else if (!guard_ok) begin
            guard_cnt <= guard_cnt + 24'h000001;
            guard_ok <= (guard_cnt == 24'(GUARD_CYCLES - 1));
        end
    end

    // Pin leaves a flip-flop; it trails the frame by a cycle, well before the first clock rise
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            data_pin_q <= `TBX_CTRL_RST;
        end else begin
            data_pin_q <= frame_select_input_mode ? 1'b0 : pin_level;
        end
    end

    assign link.sck = sck_q;
    assign link.sdi = sdi_q;
    assign link.cs_n = cs_n_q;
    assign link.data_pin = data_pin_q;
endmodule

// ### rtl/tbx_link_if.sv
`timescale 1ns/1ps
interface tbx_link_if;
    logic sck;
    logic sdi;
    logic cs_n;
    logic data_pin;
    logic sdo;
    logic irq;
    modport dev (input sck, input sdi, input cs_n, input data_pin, output sdo, output irq);
    modport host (output sck, output sdi, output cs_n, output data_pin, input sdo, input irq);
endinterface

// ### rtl/tbx_pkg.sv
package tbx_pkg;
    typedef enum logic [1:0] {TBX_OFF, TBX_CAL, TBX_SEND} tbx_tx_state_e;
    typedef enum logic {TBX_SPI_IDLE, TBX_SPI_SHIFT} tbx_spi_state_e;
endpackage

// ### rtl/tbx_sync.sv
`timescale 1ns/1ps
module tbx_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= INIT;
            q <= INIT;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// ### verification/tb_tx_buffered_byte_transmitter.sv
`timescale 1ns/1ps
`include "tbx_cfg.svh"
module tb_tx_buffered_byte_transmitter;
    localparam int BITC = 40;
    logic hclk;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    logic host_irq;
    logic osc_on;
    logic synth_on;
    logic pa_on;
    logic tx_active;
    logic fsk_bit;
    logic rf_sign;
    logic [7:0] dev_khz;
    logic [31:0] stream;
    int bad_count;
    int checks;
    tbx_link_if tbx_link_if_i ();
    tbx_device #(.BIT_CYCLES(BITC), .CAL_CYCLES(4)) tbx_device_i (.hclk(hclk), .hresetn(hresetn),
        .link(tbx_link_if_i), .osc_on(osc_on), .synth_on(synth_on), .pa_on(pa_on), .tx_active(tx_active),
        .fsk_bit(fsk_bit), .rf_sign(rf_sign), .dev_khz(dev_khz));
    tbx_host #(.SCK_HALF(4), .GUARD_CYCLES(16 * BITC)) tbx_host_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .host_irq(host_irq), .link(tbx_link_if_i));
    tbx_link_monitor #(.BIT_CYCLES(BITC)) tbx_link_monitor_i (.hclk(hclk), .hresetn(hresetn),
        .sck(tbx_link_if_i.sck), .cs_n(tbx_link_if_i.cs_n), .data_pin(tbx_link_if_i.data_pin),
        .sdo(tbx_link_if_i.sdo), .irq(tbx_link_if_i.irq), .osc_on(osc_on), .synth_on(synth_on),
        .pa_on(pa_on), .tx_active(tx_active), .fsk_bit(fsk_bit));
    always #10 hclk = ~hclk;
    task automatic summarize();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic give_up(input string what);
        bad_count++;
        $display("unexpected %s: expected event seen none", what);
        summarize();
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'h1) begin
            n++;
            if (n > 50) give_up("hreadyout");
            @(posedge hclk);
        end
    endtask
    task automatic ahb(input logic wr, input logic [7:0] ofs, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'h1;
        haddr <= {24'h0, ofs};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask
    task automatic rdc(input string name, input logic [7:0] ofs, input logic [31:0] mask, input logic [31:0] exp);
        logic [31:0] d;
        ahb(1'h0, ofs, 32'h0, d);
        chk(name, exp, d & mask);
    endtask
    task automatic wr(input logic [7:0] ofs, input logic [31:0] v);
        logic [31:0] d;
        ahb(1'h1, ofs, v, d);
    endtask
    // Commands are refused while a frame runs, so every send waits for the link to go idle
    task automatic send(input logic [7:0] ofs, input logic [15:0] v);
        logic [31:0] d;
        int n;
        wr(ofs, {16'h0, v});
        repeat (2) @(posedge hclk);
        n = 0;
        d = 32'h1;
        while (d[0] !== 1'h0) begin
            n++;
            if (n > 200) give_up("link idle");
            ahb(1'h0, `TBX_OFS_STATUS, 32'h0, d);
        end
        repeat (8) @(posedge hclk);
    endtask
    task automatic wait_irq(input logic lvl);
        int n;
        n = 0;
        while (tbx_link_if_i.irq !== lvl) begin
            n++;
            if (n > 3000) give_up("irq level");
            @(posedge hclk);
        end
        repeat (2) @(posedge hclk);
    endtask
    task automatic sample_stream();
        int n;
        n = 0;
        while (tx_active !== 1'h1) begin
            n++;
            if (n > 5000) give_up("transmit start");
            @(posedge hclk);
        end
        repeat (BITC / 2) @(posedge hclk);
        for (int i = 31; i >= 0; i--) begin
            stream[i] = fsk_bit;
            repeat (BITC) @(posedge hclk);
        end
    endtask
    task automatic t_reset();
        rdc("ctrl", `TBX_OFS_CTRL, 32'h1, 32'h1);
        rdc("int_mask", `TBX_OFS_INT_MASK, 32'h7, 32'h0);
        rdc("unmapped", 8'h20, 32'hFFFFFFFF, 32'h0);
        rdc("status", `TBX_OFS_STATUS, 32'h6, 32'h2);
        rdc("int_stat", `TBX_OFS_INT_STAT, 32'h7, 32'h0);
        chk("wire_idle", 32'h5, {29'h0, tbx_link_if_i.cs_n, tbx_link_if_i.sck, tbx_link_if_i.data_pin});
        chk("hresp", 32'h0, {31'h0, hresp});
        $display("test reset done");
    endtask
    task automatic t_raw();
        wr(`TBX_OFS_CTRL, 32'h0);
        repeat (6) @(posedge hclk);
        chk("data_pin", 32'h0, {31'h0, tbx_link_if_i.data_pin});
        chk("fsk_bit", 32'h0, {31'h0, fsk_bit});
        wr(`TBX_OFS_CTRL, 32'h1);
        repeat (6) @(posedge hclk);
        chk("data_pin", 32'h1, {31'h0, tbx_link_if_i.data_pin});
        chk("fsk_bit", 32'h1, {31'h0, fsk_bit});
        $display("test raw pin done");
    endtask
    task automatic t_dev();
        logic [3:0] w;
        logic pol;
        for (int i = 0; i < 3; i++) begin
            w = (i == 2) ? 4'hF : 4'(i * 7);
            pol = i[0];
            send(`TBX_OFS_CMD, {8'h80, 3'h0, pol, w});
            chk("dev_khz", 32'((int'(w) + 1) * 15), {24'h0, dev_khz});
            chk("rf_sign", {31'h0, ~pol}, {31'h0, rf_sign});
        end
        $display("test deviation done");
    endtask
    task automatic t_tx();
        logic [7:0] data [3];
        int n;
        logic [31:0] d;
        data = '{8'h3C, 8'h81, 8'h5A};
        wr(`TBX_OFS_INT_MASK, 32'h1);
        send(`TBX_OFS_CMD, 16'h8087);
        chk("irq_sdo", 32'h1, {30'h0, tbx_link_if_i.irq, tbx_link_if_i.sdo});
        fork
            sample_stream();
        join_none
        send(`TBX_OFS_CMD, 16'h8220);
        chk("osc_synth", 32'h3, {30'h0, osc_on, synth_on});
        for (int i = 0; i < 3; i++) begin
            wait_irq(1'h1);
            chk("irq_sdo", 32'h2, {30'h0, tbx_link_if_i.irq, tbx_link_if_i.sdo});
            if (i == 0) begin
                repeat (6) @(posedge hclk);
                chk("host_irq", 32'h1, {31'h0, host_irq});
                wr(`TBX_OFS_INT_STAT, 32'h7);
                repeat (2) @(posedge hclk);
                chk("host_irq", 32'h0, {31'h0, host_irq});
            end
            if (i < 2)
                send(`TBX_OFS_CMD, {8'hB8, data[i]});
            else
                send(`TBX_OFS_FRAME, {8'h0, data[i]});
            chk("irq_sdo", 32'h1, {30'h0, tbx_link_if_i.irq, tbx_link_if_i.sdo});
        end
        rdc("guard_ok", `TBX_OFS_STATUS, 32'h8, 32'h0);
        wait_irq(1'h1);
        chk("irq_sdo", 32'h2, {30'h0, tbx_link_if_i.irq, tbx_link_if_i.sdo});
        chk("stream", 32'hAAAA3C81, stream);
        n = 0;
        d = 32'h0;
        while (d[3] !== 1'h1) begin
            n++;
            if (n > 400) give_up("guard_ok");
            ahb(1'h0, `TBX_OFS_STATUS, 32'h0, d);
        end
        send(`TBX_OFS_CMD, 16'h8200);
        chk("pa_on", 32'h0, {31'h0, pa_on});
        send(`TBX_OFS_CMD, 16'h8007);
        chk("irq_sdo", 32'h2, {30'h0, tbx_link_if_i.irq, tbx_link_if_i.sdo});
        wr(`TBX_OFS_INT_MASK, 32'h0);
        repeat (3) @(posedge hclk);
        chk("host_irq", 32'h0, {31'h0, host_irq});
        rdc("int_stat", `TBX_OFS_INT_STAT, 32'h3, 32'h3);
        wr(`TBX_OFS_INT_STAT, 32'h7);
        rdc("int_stat", `TBX_OFS_INT_STAT, 32'h7, 32'h0);
        $display("test buffered transmit done");
    endtask
    initial begin
        hclk = 1'h0;
        hresetn = 1'h0;
        hsel = 1'h0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
        bad_count = 0;
        checks = 0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        t_reset();
        t_raw();
        t_dev();
        t_tx();
        summarize();
    end
endmodule

// ### verification/tbx_link_monitor.sv
`timescale 1ns/1ps
module tbx_link_monitor #(
    parameter int BIT_CYCLES = 40
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic data_pin,
    input wire logic sdo,
    input wire logic irq,
    input wire logic osc_on,
    input wire logic synth_on,
    input wire logic pa_on,
    input wire logic tx_active,
    input wire logic fsk_bit
);
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    int gap;
    logic irq_q;
    logic gap_ok;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_q <= 1'h1;
            gap <= 0;
        end else begin
            irq_q <= irq;
            gap <= (irq && !irq_q) ? 1 : gap + 1;
        end
    end
    // Spacing is only judged once a completion inside one burst has anchored it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            gap_ok <= 1'h0;
        else if (!tx_active)
            gap_ok <= 1'h0;
        else if (irq && !irq_q)
            gap_ok <= 1'h1;
    end
    property p_sdo_irq;
        sdo == !irq;
    endproperty
    a_sdo_irq: assert property (p_sdo_irq) else $error("sdo not inverse of irq");
    property p_pa_chain;
        $rose(pa_on) |-> osc_on && synth_on;
    endproperty
    a_pa_chain: assert property (p_pa_chain) else $error("amplifier on without oscillator");
    property p_cal;
        $rose(synth_on) |-> !pa_on [*3] ##[1:8] pa_on;
    endproperty
    a_cal: assert property (p_cal) else $error("calibration time wrong");
    property p_active_pa;
        tx_active |-> pa_on;
    endproperty
    a_active_pa: assert property (p_active_pa) else $error("sending without amplifier");
    property p_first_bit;
        $rose(tx_active) |-> ##1 fsk_bit [*8];
    endproperty
    a_first_bit: assert property (p_first_bit) else $error("first bit not one");
    property p_byte_time;
        $rose(irq) && tx_active && gap_ok |-> (gap % (8 * BIT_CYCLES)) == 0;
    endproperty
    a_byte_time: assert property (p_byte_time) else $error("byte spacing wrong");
    property p_pa_off;
        $fell(synth_on) |-> ##[0:2] !pa_on;
    endproperty
    a_pa_off: assert property (p_pa_off) else $error("amplifier stayed on");
    property p_sck_idle;
        cs_n && data_pin |-> !sck;
    endproperty
    a_sck_idle: assert property (p_sck_idle) else $error("link clock outside frame");
endmodule
